// file: core/awct_pfi_cond.sv
// selects one input line, synchronises it, applies polarity, finds its edge
`timescale 1ns/10ps
module awct_pfi_cond #(
    parameter int N = 10
) (
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    // line select
    input  wire logic [N-1:0]     i_pfi,
    input  wire logic [3:0]       i_sel,
    input  wire logic             i_invert,
    // conditioned signal
    output logic                  o_level,
    output logic                  o_edge
);

    // ==================================================
    // state
    typedef struct packed {
        logic s1;
        logic s2;
        logic lv;
        logic ev;
    } awct_cond_t;

    awct_cond_t s;
    awct_cond_t n;
    logic       pick;

    assign pick = (32'(i_sel) < N) ? i_pfi[i_sel] : 1'b0;

    // sync before polarity so the edge is a single clean cycle
    always_comb begin
        n    = s;
        n.s1 = pick;
        n.s2 = s.s1;
        n.lv = s.s2 ^ i_invert;
        n.ev = n.lv & ~s.lv;
        if (i_rst) begin
            n = '0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        s <= n;
    end

    assign o_level = s.lv;
    assign o_edge  = s.ev;

endmodule

// file: core/awct_pkg.sv
// shared constants and carriers of the acquisition/waveform/counter timing block
package awct_pkg;

    // ==================================================
    // geometry
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int NUM_PFI = 10;
    localparam int SEL_W   = 4;
    localparam int NSIG    = 10;
    localparam int CTRL_W  = 13;
    localparam int MODE_W  = 10;

    // ==================================================
    // register offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_MODE     = 8'h04;
    localparam logic [7:0] REG_POL      = 8'h08;
    localparam logic [7:0] REG_SEL0     = 8'h0C;
    localparam logic [7:0] REG_SEL1     = 8'h10;
    localparam logic [7:0] REG_SI_LOAD  = 8'h14;
    localparam logic [7:0] REG_SCAN_LD  = 8'h18;
    localparam logic [7:0] REG_UI_LOAD  = 8'h1C;
    localparam logic [7:0] REG_CONV_N   = 8'h20;
    localparam logic [7:0] REG_BUF_N    = 8'h24;
    localparam logic [7:0] REG_C0_LOAD  = 8'h28;
    localparam logic [7:0] REG_C0_COUNT = 8'h2C;
    localparam logic [7:0] REG_C0_LATCH = 8'h30;
    localparam logic [7:0] REG_STATUS   = 8'h34;

    // ==================================================
    // control bits
    localparam int B_SEQ        = 0;
    localparam int B_AI_SWGATE  = 1;
    localparam int B_GATE_EDGE  = 2;
    localparam int B_DAC_SWGATE = 3;
    localparam int B_UI_STOP    = 4;
    localparam int B_DAC_POSTED = 5;
    localparam int B_C0_EN      = 6;
    localparam int B_C0_TOGGLE  = 7;
    localparam int B_C0_POL     = 8;
    localparam int B_DIR_EXT    = 9;
    localparam int B_DIR_UP     = 10;
    localparam int B_PIN_OE     = 11;
    localparam int B_C0_LATCH   = 12;

    // mode bits
    localparam int M_START_EXT = 0;
    localparam int M_CONV_EXT  = 1;
    localparam int M_UPD_EXT   = 2;
    localparam int M_SI_EXT    = 3;
    localparam int M_SI_SLOW   = 4;
    localparam int M_UI_EXT    = 5;
    localparam int M_UI_SLOW   = 6;
    localparam int M_C0_EXT    = 7;
    localparam int M_C0_SLOW   = 8;
    localparam int M_C1_EXT    = 9;

    // ==================================================
    // conditioned input channels
    localparam int SIG_START  = 0;
    localparam int SIG_GATE   = 1;
    localparam int SIG_SICLK  = 2;
    localparam int SIG_CONV   = 3;
    localparam int SIG_WFT    = 4;
    localparam int SIG_UPD    = 5;
    localparam int SIG_UICLK  = 6;
    localparam int SIG_C0CLK  = 7;
    localparam int SIG_C0GATE = 8;
    localparam int SIG_C1CLK  = 9;

    // ==================================================
    // timing
    localparam int CLK_HZ        = 50_000_000;
    localparam int CLK_NS        = 20;
    localparam int TB_FAST_HZ    = 20_000_000;
    localparam int TB_SLOW_HZ    = 100_000;
    localparam int WFT_PULSE_NS  = 50;
    localparam int UPD_PULSE_NS  = 300;
    localparam int WFT_CYC       = (WFT_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int UPD_CYC       = (UPD_PULSE_NS + CLK_NS - 1) / CLK_NS;

    // reset values
    localparam logic [15:0] CONV_N_RST = 16'h0001;

    // ==================================================
    // register port carrier
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } awct_bus_t;

endpackage

// file: core/awct_tick.sv
// fractional divider: one-cycle enable at an average rate of TICK_HZ
`timescale 1ns/10ps
module awct_tick #(
    parameter int CLK_HZ  = 50_000_000,
    parameter int TICK_HZ = 20_000_000
) (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    // enable
    output logic      o_tick
);

    // ==================================================
    // state
    typedef struct packed {
        logic [31:0] acc;
        logic        tick;
    } awct_tick_t;

    awct_tick_t s;
    awct_tick_t n;

    // jitter of one clock is accepted for non-integer ratios
    always_comb begin
        n      = s;
        n.acc  = s.acc + 32'(TICK_HZ);
        n.tick = 1'b0;
        if (n.acc >= 32'(CLK_HZ)) begin
            n.acc  = n.acc - 32'(CLK_HZ);
            n.tick = 1'b1;
        end
        if (i_rst) begin
            n = '0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        s <= n;
    end

    assign o_tick = s.tick;

endmodule

// file: core/awct_top.sv
// acquisition scan gating, waveform timing and counter 0 timing controller
//
// Overview of operation
// RL1 - sample counter times conversions within each scan
// RL2 - no conversion strobe outside acquisition sequence
// RL3 - scans blockable by gate input or software
// RL4 - gate input from any line, level/edge, polarity
// RL5 - level gate active masks scan start
// RL6 - edge gate alternately disables and enables starts
// RL7 - gating takes effect only at scan start
// RL8 - scan interval clock: timebase or level input
// RL9 - waveform trigger edge starts generation and counter
// RL10 - trigger output high pulse, tri-state after reset
// RL11 - update edge updates DACs in posted mode
// RL12 - update output low pulse, tri-state after reset
// RL13 - external updates spaced for DAC data writes; the design passes each external update edge on without spacing
// RL14 - update counter makes updates, stops by software/buffer
// RL15 - software gate blocks every DAC update
// RL16 - update interval clock: timebase or level input
// RL17 - counter0 clock selectable, mirrored, tri-state after reset
// RL18 - counter0 gate edge runs/stops or latches
// RL19 - counter0 output pulse or toggle, polarity
// RL20 - direction line six or software sets direction
// RL21 - counter1 clock from selected line edge
// RL22 - scan start edge begins scan, starts sampling
// RL23 - conversions masked until scan start occurs
// RL24 - inputs synchronised before polarity and detection
`timescale 1ns/10ps
module awct_top #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_rst,
    // register port
    input  wire awct_pkg::awct_bus_t       i_bus,
    output logic [awct_pkg::DATA_W-1:0]    o_rdata,
    // input lines
    input  wire logic [awct_pkg::NUM_PFI-1:0] i_pfi,
    input  wire logic                      i_digital_line_six,
    // converter and DAC strobes
    output logic                           o_conv_strobe,
    output logic                           o_dac_update,
    // mirrored pins
    output logic                           o_waveform_trigger,
    output logic                           o_dac_update_strobe_n,
    output logic                           o_counter0_clock,
    output logic                           o_counter0_gate,
    output logic                           o_counter0_output,
    output logic                           o_pin_oe,
    // counter 1 clock enable
    output logic                           o_counter1_clock
);
    import awct_pkg::*;

    // ==================================================
    // state
    typedef struct packed {
        logic [CTRL_W-1:0]          ctrl;
        logic [MODE_W-1:0]          mode;
        logic [NSIG-1:0]            pol;
        logic [NSIG-1:0][SEL_W-1:0] sel;
        logic [CNT_W-1:0]           si_load;
        logic [CNT_W-1:0]           scan_load;
        logic [CNT_W-1:0]           ui_load;
        logic [CNT_W-1:0]           conv_n;
        logic [CNT_W-1:0]           buf_n;
        logic [CNT_W-1:0]           c0_load;
        logic [CNT_W-1:0]           scan_cnt;
        logic [CNT_W-1:0]           si_cnt;
        logic [CNT_W-1:0]           conv_left;
        logic                       in_scan;
        logic                       gate_tog;
        logic                       wf_run;
        logic [CNT_W-1:0]           ui_cnt;
        logic [CNT_W-1:0]           buf_left;
        logic [3:0]                 wft_cnt;
        logic [4:0]                 upd_cnt;
        logic [CNT_W-1:0]           c0_cnt;
        logic [CNT_W-1:0]           c0_latch;
        logic                       c0_halt;
        logic                       c0_raw;
        logic                       dio_s1;
        logic                       dio_s2;
        logic                       conv;
        logic                       dac_upd;
        logic                       wf_trig;
        logic                       upd_n;
        logic                       c0_clk;
        logic                       c0_gate;
        logic                       c0_out;
        logic                       c1_clk;
        logic [DATA_W-1:0]          rdata;
    } awct_state_t;

    awct_state_t     s;
    awct_state_t     n;
    logic [NSIG-1:0] lv;
    logic [NSIG-1:0] ev;
    logic            tb_fast;
    logic            tb_slow;
    logic            si_tick;
    logic            ui_tick;
    logic            c0_tick;
    logic            start_evt;
    logic            blocked;
    logic            start_ok;
    logic            conv_evt;
    logic            scan_done;
    logic            upd_req;
    logic            upd_ok;
    logic            wf_start;
    logic            dir_up;
    logic            c0_tc;

    // ==================================================
    // timebases and input conditioning
    awct_tick #(.CLK_HZ(CLK_HZ), .TICK_HZ(TB_FAST_HZ)) u_tb_fast (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .o_tick    (tb_fast)
    );

    awct_tick #(.CLK_HZ(CLK_HZ), .TICK_HZ(TB_SLOW_HZ)) u_tb_slow (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .o_tick    (tb_slow)
    );

    for (genvar g = 0; g < NSIG; g++) begin : g_cond
        awct_pfi_cond #(.N(NUM_PFI)) u_cond (  // RL24 RL4
            .i_ref_clk (i_ref_clk),
            .i_rst     (i_rst),
            .i_pfi     (i_pfi),
            .i_sel     (s.sel[g]),
            .i_invert  (s.pol[g]),
            .o_level   (lv[g]),
            .o_edge    (ev[g])
        );
    end

    // external clock in level mode counts on each start of the active level
    function automatic logic clk_pick(input logic ext, input logic slow, input logic pin_ev,
                                      input logic f, input logic sl);
        return ext ? pin_ev : (slow ? sl : f);
    endfunction

    // ==================================================
    // event decode
    always_comb begin
        si_tick = clk_pick(s.mode[M_SI_EXT], s.mode[M_SI_SLOW], ev[SIG_SICLK],
                           tb_fast, tb_slow);  // RL8
        ui_tick = clk_pick(s.mode[M_UI_EXT], s.mode[M_UI_SLOW], ev[SIG_UICLK],
                           tb_fast, tb_slow);  // RL16
        c0_tick = clk_pick(s.mode[M_C0_EXT], s.mode[M_C0_SLOW], ev[SIG_C0CLK],
                           tb_fast, tb_slow);  // RL17
        start_evt = s.mode[M_START_EXT] ? ev[SIG_START]
                  : (s.ctrl[B_SEQ] & si_tick & (s.scan_cnt == '0));  // RL22
        blocked   = s.ctrl[B_AI_SWGATE]
                  | (s.ctrl[B_GATE_EDGE] ? s.gate_tog : lv[SIG_GATE]);  // RL3 RL5 RL6
        start_ok  = start_evt & s.ctrl[B_SEQ] & ~s.in_scan & ~blocked;  // RL7
        conv_evt  = s.in_scan & s.ctrl[B_SEQ]
                  & (s.mode[M_CONV_EXT] ? ev[SIG_CONV]
                                        : (tb_fast & (s.si_cnt == '0)));  // RL2 RL23
        scan_done = s.in_scan & (~s.ctrl[B_SEQ] | (conv_evt & (s.conv_left <= 1)));
        wf_start  = ev[SIG_WFT] & ~s.wf_run & (s.wft_cnt == 4'h0);  // RL9
        upd_req   = s.mode[M_UPD_EXT] ? ev[SIG_UPD]
                  : (s.wf_run & ui_tick & (s.ui_cnt == '0));  // RL14
        upd_ok    = upd_req & s.ctrl[B_DAC_POSTED] & ~s.ctrl[B_DAC_SWGATE];  // RL11 RL15
        dir_up    = s.ctrl[B_DIR_EXT] ? s.dio_s2 : s.ctrl[B_DIR_UP];  // RL20
        c0_tc     = dir_up ? (s.c0_cnt == '1) : (s.c0_cnt == '0);
    end

    // ==================================================
    // next state
    always_comb begin
        n         = s;
        n.conv    = 1'b0;
        n.dac_upd = 1'b0;
        n.c0_clk  = 1'b0;
        n.dio_s1  = i_digital_line_six;
        n.dio_s2  = s.dio_s1;

        // scan interval counter
        if (s.ctrl[B_SEQ] & si_tick) begin
            n.scan_cnt = (s.scan_cnt == '0) ? s.scan_load : s.scan_cnt - 1'b1;
        end

        // edge gate alternates on each active edge
        if (s.ctrl[B_GATE_EDGE] & ev[SIG_GATE]) begin
            n.gate_tog = ~s.gate_tog;  // RL6
        end

        // sample interval counter
        if (s.in_scan & ~s.mode[M_CONV_EXT] & tb_fast) begin
            n.si_cnt = (s.si_cnt == '0) ? s.si_load : s.si_cnt - 1'b1;  // RL1
        end
        if (start_ok) begin
            n.in_scan   = 1'b1;  // RL22
            n.si_cnt    = s.si_load;
            n.conv_left = s.conv_n;
        end
        if (conv_evt) begin
            n.conv      = 1'b1;
            n.conv_left = s.conv_left - 1'b1;
        end
        if (scan_done) begin
            n.in_scan = 1'b0;  // RL1
            n.si_cnt  = s.si_load;
        end

        // waveform trigger and its pin pulse
        if (s.wft_cnt != 4'h0) begin
            n.wft_cnt = s.wft_cnt - 4'h1;
        end
        if (wf_start) begin
            n.wf_run   = 1'b1;  // RL9
            n.ui_cnt   = s.ui_load;
            n.buf_left = s.buf_n;
            n.wft_cnt  = 4'(WFT_CYC);  // RL10
        end

        // update interval counter
        if (s.wf_run & ~s.mode[M_UPD_EXT] & ui_tick) begin
            n.ui_cnt = (s.ui_cnt == '0) ? s.ui_load : s.ui_cnt - 1'b1;  // RL14
        end
        if (s.upd_cnt != 5'h00) begin
            n.upd_cnt = s.upd_cnt - 5'h01;
        end
        if (upd_ok) begin
            n.dac_upd = 1'b1;
            n.upd_cnt = 5'(UPD_CYC);  // RL12
            if (s.wf_run & (s.buf_left != '0)) begin
                n.buf_left = s.buf_left - 1'b1;
                if (s.buf_left == 1) begin
                    n.wf_run = 1'b0;  // RL14
                end
            end
        end

        // counter 0
        n.c0_gate = lv[SIG_C0GATE];  // RL18
        if (ev[SIG_C0GATE]) begin
            if (s.ctrl[B_C0_LATCH]) begin
                n.c0_latch = s.c0_cnt;  // RL18
            end else begin
                n.c0_halt = ~s.c0_halt;  // RL18
            end
        end
        if (~s.ctrl[B_C0_TOGGLE]) begin
            n.c0_raw = 1'b0;
        end
        if (c0_tick) begin
            n.c0_clk = 1'b1;  // RL17
        end
        if (c0_tick & s.ctrl[B_C0_EN] & ~s.c0_halt) begin
            if (c0_tc) begin
                n.c0_cnt = s.c0_load;
                n.c0_raw = s.ctrl[B_C0_TOGGLE] ? ~s.c0_raw : 1'b1;  // RL19
            end else begin
                n.c0_cnt = dir_up ? s.c0_cnt + 1'b1 : s.c0_cnt - 1'b1;  // RL20
            end
        end

        // counter 1 clock
        n.c1_clk = s.mode[M_C1_EXT] ? ev[SIG_C1CLK] : tb_fast;  // RL21

        // register writes
        if (i_bus.wr) begin
            case (i_bus.addr)
                REG_CTRL: begin
                    n.ctrl = i_bus.wdata[CTRL_W-1:0];
                    n.ctrl[B_UI_STOP] = 1'b0;
                    if (i_bus.wdata[B_UI_STOP] & ~wf_start) begin
                        n.wf_run = 1'b0;  // RL14
                    end
                end
                REG_MODE:    n.mode = i_bus.wdata[MODE_W-1:0];
                REG_POL:     n.pol = i_bus.wdata[NSIG-1:0];
                REG_SEL0:    n.sel[7:0] = i_bus.wdata;
                REG_SEL1:    n.sel[9:8] = i_bus.wdata[7:0];
                REG_SI_LOAD: n.si_load = i_bus.wdata[CNT_W-1:0];
                REG_SCAN_LD: n.scan_load = i_bus.wdata[CNT_W-1:0];
                REG_UI_LOAD: n.ui_load = i_bus.wdata[CNT_W-1:0];
                REG_CONV_N:  n.conv_n = i_bus.wdata[CNT_W-1:0];
                REG_BUF_N:   n.buf_n = i_bus.wdata[CNT_W-1:0];
                REG_C0_LOAD: begin
                    n.c0_load = i_bus.wdata[CNT_W-1:0];
                    n.c0_cnt  = i_bus.wdata[CNT_W-1:0];
                end
                default: ;
            endcase
        end

        // register reads, answer one cycle later
        n.rdata = '0;
        if (i_bus.rd) begin
            case (i_bus.addr)
                REG_CTRL:     n.rdata = DATA_W'(s.ctrl);
                REG_MODE:     n.rdata = DATA_W'(s.mode);
                REG_POL:      n.rdata = DATA_W'(s.pol);
                REG_SEL0:     n.rdata = s.sel[7:0];
                REG_SEL1:     n.rdata = DATA_W'(s.sel[9:8]);
                REG_SI_LOAD:  n.rdata = DATA_W'(s.si_load);
                REG_SCAN_LD:  n.rdata = DATA_W'(s.scan_load);
                REG_UI_LOAD:  n.rdata = DATA_W'(s.ui_load);
                REG_CONV_N:   n.rdata = DATA_W'(s.conv_n);
                REG_BUF_N:    n.rdata = DATA_W'(s.buf_n);
                REG_C0_LOAD:  n.rdata = DATA_W'(s.c0_load);
                REG_C0_COUNT: n.rdata = DATA_W'(s.c0_cnt);
                REG_C0_LATCH: n.rdata = DATA_W'(s.c0_latch);
                REG_STATUS:   n.rdata = DATA_W'({dir_up, s.c0_halt, s.c0_out, s.wf_run,
                                                 blocked, s.in_scan});
                default:      n.rdata = '0;
            endcase
        end

        // pin images, all registered
        n.wf_trig = (n.wft_cnt != 4'h0);  // RL10
        n.upd_n   = (n.upd_cnt == 5'h00);  // RL12
        n.c0_out  = n.c0_raw ^ n.ctrl[B_C0_POL];  // RL19

        // pins start tri-stated until software enables them
        if (i_rst) begin
            n        = '0;
            n.conv_n = CONV_N_RST[CNT_W-1:0];
            n.upd_n  = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        s <= n;
    end

    // ==================================================
    // outputs
    assign o_rdata               = s.rdata;
    assign o_conv_strobe         = s.conv;
    assign o_dac_update          = s.dac_upd;
    assign o_waveform_trigger    = s.wf_trig;
    assign o_dac_update_strobe_n = s.upd_n;
    assign o_counter0_clock      = s.c0_clk;
    assign o_counter0_gate       = s.c0_gate;
    assign o_counter0_output     = s.c0_out;
    assign o_pin_oe              = s.ctrl[B_PIN_OE];  // RL10 RL12 RL17 RL18 RL19
    assign o_counter1_clock      = s.c1_clk;

    // ==================================================
    // checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence wft_high3;
        o_waveform_trigger [*3];
    endsequence

    sequence upd_low15;
        !o_dac_update_strobe_n [*8] ##1 !o_dac_update_strobe_n [*7];
    endsequence

    a_conv_in_scan: assert property (o_conv_strobe |-> $past(s.in_scan && s.ctrl[B_SEQ]))  // RL2
        else $error("conversion strobe outside an active scan");
    a_wft_pulse_width: assert property (wf_start |=> wft_high3 ##1 !o_waveform_trigger)  // RL10
        else $error("trigger pulse width wrong");
    a_upd_pulse_width: assert property (upd_ok |=> upd_low15)  // RL12
        else $error("update pulse too short");
    a_gate_blocks_start: assert property (start_evt && blocked && !s.in_scan |=> !s.in_scan)  // RL3
        else $error("scan began while gated");
    a_scan_holds: assert property (s.in_scan && !scan_done |=> s.in_scan)  // RL7
        else $error("scan stopped mid way");
    a_dac_sw_gate: assert property (o_dac_update |-> !$past(s.ctrl[B_DAC_SWGATE]))  // RL15
        else $error("update passed the software gate");
    a_pins_reset_off: assert property ($past(i_rst) |-> !o_pin_oe)  // RL10
        else $error("pins driven after reset");
    a_c0_count_down: assert property (c0_tick && s.ctrl[B_C0_EN] && !s.c0_halt && !c0_tc
                                      && !dir_up && !i_bus.wr
                                      |=> s.c0_cnt == $past(s.c0_cnt) - 1'b1)  // RL20
        else $error("counter 0 did not count down");
    a_wf_start_runs: assert property (wf_start && !(i_bus.wr && i_bus.addr == REG_CTRL)
                                      |=> s.wf_run ##0 o_waveform_trigger)  // RL9
        else $error("waveform trigger did not start generation");

endmodule

// file: testbench/awct_pfi_src.sv
// model of the external sources that drive the input lines
`timescale 1ns/10ps
module awct_pfi_src (
    // clock
    input  wire logic       i_ref_clk,
    // pulse request
    input  wire logic       i_fire,
    input  wire logic [3:0] i_line,
    // lines
    output logic [9:0]      o_pfi
);
    logic [2:0] hold_ff = 3'h0;
    logic [3:0] line_ff = 4'h0;
    // ==========================================
    // pulse source
    // four-cycle pulse outlives the input synchroniser
    always_ff @(posedge i_ref_clk) begin
        if (i_fire) begin
            hold_ff <= 3'h4;
            line_ff <= i_line;
        end else if (hold_ff != 3'h0) begin
            hold_ff <= hold_ff - 3'h1;
        end
    end
    // one pulse per request, so updates stay spaced
    always_comb o_pfi = (hold_ff != 3'h0) ? (10'h001 << line_ff) : 10'h000;
endmodule

// file: testbench/awct_top_tb.sv
// self-checking bench of the timing controller
`timescale 1ns/10ps
module awct_top_tb;
    import awct_pkg::*;
    logic              i_ref_clk = 1'b0;
    logic              i_rst     = 1'b1;
    awct_bus_t         bus       = '0;
    logic [DATA_W-1:0] rdata;
    logic [9:0]        pfi;
    logic              dl6  = 1'b0;
    logic              fire = 1'b0;
    logic [3:0]        line = 4'h0;
    logic              cnt_en = 1'b0;
    logic              conv, upd, wft, upd_n, c0c, c0g, c0o, oe, c1c;
    int                n_conv, n_upd, n_low, n_wft, n_c0c, n_c0o, n_c0g, n_c1;
    int                n_mismatch  = 0;
    int                comparisons = 0;
    logic [31:0]       seed = 32'hE2FE9CCD;
    logic [3:0]        ln [4];

    awct_top i_awct_top (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata),
        .i_pfi(pfi), .i_digital_line_six(dl6), .o_conv_strobe(conv), .o_dac_update(upd),
        .o_waveform_trigger(wft), .o_dac_update_strobe_n(upd_n), .o_counter0_clock(c0c),
        .o_counter0_gate(c0g), .o_counter0_output(c0o), .o_pin_oe(oe),
        .o_counter1_clock(c1c));
    awct_pfi_src i_awct_pfi_src (.i_ref_clk(i_ref_clk), .i_fire(fire), .i_line(line),
        .o_pfi(pfi));

    // ==========================================
    // clock, counting, helpers
    initial forever #10 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        if (cnt_en) begin
            n_conv += conv;
            n_upd  += upd;
            n_low  += !upd_n;
            n_wft  += wft;
            n_c0c  += c0c;
            n_c0o  += c0o;
            n_c0g  += c0g;
            n_c1   += c1c;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic int fast_ticks(input int cyc);
        return cyc * (TB_FAST_HZ / 100_000) / (CLK_HZ / 100_000);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge i_ref_clk) bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_ref_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge i_ref_clk) bus.rd <= 1'b0;
        #1 check(rdata, e);
    endtask
    // counts cover the whole 40-cycle window after the pulse
    task automatic pulse(input logic [3:0] l);
        #1 {n_conv, n_upd, n_low, n_wft, n_c0c, n_c0o, n_c0g, n_c1} = '0;
        @(posedge i_ref_clk) {fire, line, cnt_en} <= {1'b1, l, 1'b1};
        @(posedge i_ref_clk) fire <= 1'b0;
        repeat (39) @(posedge i_ref_clk);
        cnt_en <= 1'b0;
        #1;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #400000 n_mismatch++;
        $display("unexpected at %0t: run did not finish", $time);
        print_verdict;
    end

    // ==========================================
    // scenarios
    initial begin
        seed = xs(seed);
        for (int i = 0; i < 4; i++) ln[i] = 4'((seed % 10 + i) % 10);
        dl6 = seed[20];
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        #1 check(oe, 1'b0);
        check(upd_n, 1'b1);
        rd(REG_CONV_N, 32'h1);
        rd(8'hFC, 32'h0);
        $display("test reset done");
        wr(REG_MODE, 32'h7);
        wr(REG_SEL0, {8'hFF, ln[3], ln[2], ln[1], 8'hFF, ln[0]});
        wr(REG_SEL1, 32'hFF);
        wr(REG_CTRL, 32'h820);
        pulse(ln[1]);
        check(n_conv, 0);
        wr(REG_CTRL, 32'h821);
        pulse(ln[1]);
        check(n_conv, 0);
        pulse(ln[0]);
        pulse(ln[1]);
        check(n_conv, 1);
        pulse(ln[1]);
        check(n_conv, 0);
        wr(REG_CTRL, 32'h823);
        pulse(ln[0]);
        wr(REG_CTRL, 32'h821);
        wr(REG_POL, 32'h2);
        pulse(ln[0]);
        pulse(ln[1]);
        check(n_conv, 0);
        wr(REG_CTRL, 32'h825);
        pulse(ln[0]);
        pulse(ln[1]);
        check(n_conv, 1);
        wr(REG_POL, 32'h0);
        wr(REG_POL, 32'h2);
        pulse(ln[0]);
        pulse(ln[1]);
        check(n_conv, 0);
        $display("test scan done");
        pulse(ln[3]);
        check(n_upd, 1);
        check(n_low, UPD_CYC);
        wr(REG_CTRL, 32'h829);
        pulse(ln[3]);
        check(n_upd + n_low, 0);
        $display("test update done");
        pulse(ln[2]);
        check(n_wft, WFT_CYC);
        check(oe, 1'b1);
        $display("test trigger done");
        wr(REG_UI_LOAD, 32'h3);
        wr(REG_CTRL, 32'h860);
        wr(REG_MODE, 32'h3);
        wr(REG_C0_LOAD, 32'h3);
        pulse(4'hF);
        check(n_c0c, fast_ticks(40));
        check(n_c0o, fast_ticks(40) / 4);
        check(n_c1, fast_ticks(40));
        check(n_upd, fast_ticks(40) / 4);
        wr(REG_CTRL, 32'hB40);
        wr(REG_C0_LOAD, dl6 ? 32'hFFFC : 32'h3);
        pulse(4'hF);
        check(n_c0o, 40 - fast_ticks(40) / 4);
        check(n_upd, 0);
        wr(REG_MODE, 32'h207);
        wr(REG_SEL1, {24'h0, ln[0], ln[0]});
        pulse(ln[0]);
        check(n_c1, 1);
        check(n_c0g, 4);
        $display("test counter done");
        print_verdict;
    end
endmodule
